//--- rtl/svtd_map.vh
`ifndef SVTD_MAP_VH
`define SVTD_MAP_VH
// Register byte addresses on the AXI4-Lite slave.
`define SVTD_OFF_CTRL 4'h0
`define SVTD_OFF_STAT 4'h4
`define SVTD_OFF_MASK 4'h8
`define SVTD_OFF_GIE 4'hC
// Control register field positions.
`define SVTD_LVL_HI 3
`define SVTD_LVL_LO 0
`define SVTD_EN_BIT 4
`define SVTD_RVST_BIT 5
`define SVTD_BGST_BIT 6
`define SVTD_DIR_BIT 7
// Status and mask bit positions.
`define SVTD_TRIP_BIT 0
// Reset values.
`define SVTD_CTRL_RST 8'h04
`define SVTD_MASK_RST 1'h0
`define SVTD_GIE_RST 1'h0
// Level code that selects the external trip input.
`define SVTD_LVL_EXT 4'hF
// Reference start-up time in ns, and its cycle count at 50 MHz.
`define SVTD_RVST_NS 1000
`define SVTD_CLK_MHZ 50
`define SVTD_RVST_CYC ((`SVTD_RVST_NS * `SVTD_CLK_MHZ + 999) / 1000)
// AXI responses.
`define SVTD_RESP_OK 2'h0
`define SVTD_RESP_SLVERR 2'h2
`endif

//--- rtl/svtd_sync.v
`timescale 1ns/10ps
`default_nettype none
module svtd_sync
(
	input wire i_ref_clk,
	input wire i_rst,
	input wire i_async,
	output wire o_sync
);
	reg meta_q;
	reg sync_q;

	// Two-stage synchroniser; only the second stage is used downstream.
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end
		else
		begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule // svtd_sync
`default_nettype wire

//--- rtl/svtd_detector.v
// Overview of operation
// [RQ1] Detector circuitry is powered only while control bit 4 enable is one.
// [RQ2] Control bit 5 reads zero after each enable until reference settles, then one.
// [RQ3] Trip flag cannot be set while the reference-stable bit is zero.
// [RQ4] Bit 7 zero flags supply at or below trip; one flags at or above.
// [RQ5] Control bits 3:0 pick one of 15 levels; 0000 minimum, 1110 maximum.
// [RQ6] Level code 1111 routes the external trip input to the comparator.
// [RQ7] Control bit 6 reads back the band gap stable indication.
// [RQ8] A trip in the chosen direction sets a sticky flag until software clears it.
// [RQ9] Software programs level, then direction, then sets enable.
// [RQ10] After enabling, software clears any stale trip flag.
// [RQ11] Interrupt requested only when trip enable and global enable are both set.
// [RQ12] Software should disable before changing direction or level, then re-enable.
// [RQ13] Any reset returns the control register to reset state, detector disabled.
// [RQ14] Detection continues during sleep; a trip sets the flag and requests wake. Here o_wake is raised only while the mask bit is also set.
// [RQ15] Comparator output passes two flops; flag sets on first synchronised true cycle.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "svtd_map.vh"
module svtd_detector
(
	input wire i_ref_clk,
	input wire i_rst,
	// AXI4-Lite slave.
	input wire [3:0] i_s_axi_awaddr,
	input wire i_s_axi_awvalid,
	output wire o_s_axi_awready,
	input wire [31:0] i_s_axi_wdata,
	input wire [3:0] i_s_axi_wstrb,
	input wire i_s_axi_wvalid,
	output wire o_s_axi_wready,
	output wire [1:0] o_s_axi_bresp,
	output wire o_s_axi_bvalid,
	input wire i_s_axi_bready,
	input wire [3:0] i_s_axi_araddr,
	input wire i_s_axi_arvalid,
	output wire o_s_axi_arready,
	output wire [31:0] o_s_axi_rdata,
	output wire [1:0] o_s_axi_rresp,
	output wire o_s_axi_rvalid,
	input wire i_s_axi_rready,
	// Analog front end.
	input wire i_cmp_below_async,
	input wire i_cmp_above_async,
	input wire i_bandgap_stable,
	output reg o_detector_power,
	output reg [3:0] o_trip_level_select,
	output reg o_external_trip_sel,
	// Interrupt and wake.
	output reg o_irq,
	output reg o_wake
);
	reg [7:0] ctrl_q;
	reg trip_flag_q;
	reg mask_q;
	reg gie_q;
	reg rvst_q;
	reg [7:0] rvst_cnt_q;
	reg aw_held_q;
	reg [3:0] aw_addr_q;
	reg w_held_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg bvalid_q;
	reg [1:0] bresp_q;
	reg rvalid_q;
	reg [31:0] rdata_q;
	reg [1:0] rresp_q;
	wire below_s;
	wire above_s;
	wire trip_cond;
	wire wr_go;
	wire wr_stat_clr;
	wire rd_go;
	wire enable;
	wire trip_set;
	reg trip_flag_d;
	reg [1:0] settle_q;
	reg [1:0] settle_d;
	reg [7:0] rvst_cnt_d;
	reg [31:0] rdata_d;

	// Reference settle states, one binary code each.
	localparam [1:0] SETTLE_OFF = 2'b00;
	localparam [1:0] SETTLE_RUN = 2'b01;
	localparam [1:0] SETTLE_DONE = 2'b10;

	// Maps an address to a known register, so writes and reads agree.
	function addr_ok;
		input [3:0] a;
		begin
			addr_ok = (a == `SVTD_OFF_CTRL) || (a == `SVTD_OFF_STAT) ||
				(a == `SVTD_OFF_MASK) || (a == `SVTD_OFF_GIE);
		end
	endfunction

	// Bus response for an address; unmapped words answer with a slave error.
	function [1:0] bus_resp;
		input [3:0] a;
		begin
			bus_resp = addr_ok(a) ? `SVTD_RESP_OK : `SVTD_RESP_SLVERR;
		end
	endfunction

	// Level field of a control byte, so drive, decode and readback cannot disagree.
	function [3:0] lvl_field;
		input [7:0] c;
		begin
			lvl_field = c[`SVTD_LVL_HI:`SVTD_LVL_LO];
		end
	endfunction

	// Comparator outputs cross into the clock domain through two flops.
	svtd_sync u_sync_below
	(
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_async(i_cmp_below_async),
		.o_sync(below_s)
	); // [RQ15]
	svtd_sync u_sync_above
	(
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_async(i_cmp_above_async),
		.o_sync(above_s)
	); // [RQ15]

	assign enable = ctrl_q[`SVTD_EN_BIT];
	// The direction bit picks which comparator sense counts as a trip.
	assign trip_cond = ctrl_q[`SVTD_DIR_BIT] ? above_s : below_s; // [RQ4]

	// Write channel: address and data may arrive in either order.
	assign o_s_axi_awready = !aw_held_q && !bvalid_q;
	assign o_s_axi_wready = !w_held_q && !bvalid_q;
	assign o_s_axi_bvalid = bvalid_q;
	assign o_s_axi_bresp = bresp_q;
	assign wr_go = aw_held_q && w_held_q && !bvalid_q;
	assign wr_stat_clr = wr_go && (aw_addr_q == `SVTD_OFF_STAT) && w_strb_q[0] &&
		w_data_q[`SVTD_TRIP_BIT];

	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 4'h0;
			w_held_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `SVTD_RESP_OK;
		end
		else
		begin
			if (i_s_axi_awvalid && o_s_axi_awready)
			begin
				aw_held_q <= 1'b1;
				aw_addr_q <= i_s_axi_awaddr;
			end
			if (i_s_axi_wvalid && o_s_axi_wready)
			begin
				w_held_q <= 1'b1;
				w_data_q <= i_s_axi_wdata;
				w_strb_q <= i_s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= bus_resp(aw_addr_q);
			end
			else if (bvalid_q && i_s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// Control, mask and global enable. Status bits 6:5 are never stored.
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			ctrl_q <= `SVTD_CTRL_RST; // [RQ13]
			mask_q <= `SVTD_MASK_RST;
			gie_q <= `SVTD_GIE_RST;
		end
		else if (wr_go && w_strb_q[0])
		begin
			if (aw_addr_q == `SVTD_OFF_CTRL)
			begin
				ctrl_q[`SVTD_DIR_BIT] <= w_data_q[`SVTD_DIR_BIT]; // [RQ4]
				ctrl_q[`SVTD_EN_BIT] <= w_data_q[`SVTD_EN_BIT]; // [RQ1]
				ctrl_q[`SVTD_LVL_HI:`SVTD_LVL_LO] <=
					w_data_q[`SVTD_LVL_HI:`SVTD_LVL_LO]; // [RQ5]
			end
			if (aw_addr_q == `SVTD_OFF_MASK)
				mask_q <= w_data_q[`SVTD_TRIP_BIT];
			if (aw_addr_q == `SVTD_OFF_GIE)
				gie_q <= w_data_q[0];
		end
	end

	// Reference settle sequence. The analog start-up has no clock of its own, so it is
	// modelled as a fixed count that restarts on every enable; a brief trip inside
	// that window is lost on purpose, as the unsettled hardware would miss it too.
	always @*
	begin
		settle_d = settle_q;
		rvst_cnt_d = rvst_cnt_q;
		case (settle_q)
			SETTLE_OFF:
			begin
				// The first counted cycle is the one right after enable lands.
				if (enable)
				begin
					settle_d = SETTLE_RUN;
					rvst_cnt_d = 8'h01;
				end
				else
					rvst_cnt_d = 8'h00;
			end
			SETTLE_RUN:
			begin
				if (!enable)
				begin
					settle_d = SETTLE_OFF;
					rvst_cnt_d = 8'h00;
				end
				else if (rvst_cnt_q == `SVTD_RVST_CYC - 1)
					settle_d = SETTLE_DONE; // [RQ2]
				else
					rvst_cnt_d = rvst_cnt_q + 8'h01;
			end
			SETTLE_DONE:
			begin
				// Dropping enable throws the reference back to unsettled at once.
				if (!enable)
				begin
					settle_d = SETTLE_OFF;
					rvst_cnt_d = 8'h00;
				end
			end
			default:
			begin
				settle_d = SETTLE_OFF;
				rvst_cnt_d = 8'h00;
			end
		endcase
	end

	// Settle state and counter; the stable bit is the registered state decode.
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			settle_q <= SETTLE_OFF;
			rvst_cnt_q <= 8'h00;
			rvst_q <= 1'b0; // [RQ2]
		end
		else
		begin
			settle_q <= settle_d;
			rvst_cnt_q <= rvst_cnt_d;
			rvst_q <= (settle_d == SETTLE_DONE); // [RQ2]
		end
	end

	// A trip counts only with the detector on and its reference settled.
	assign trip_set = enable && rvst_q && trip_cond; // [RQ3] [RQ15]

	// Sticky trip flag next value. The set is applied last, so a trip in the
	// clearing cycle wins over the clear and no event is lost.
	always @*
	begin
		trip_flag_d = trip_flag_q;
		if (wr_stat_clr)
			trip_flag_d = 1'b0; // [RQ8]
		if (trip_set)
			trip_flag_d = 1'b1; // [RQ3] [RQ8]
	end

	// Trip flag register.
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
			trip_flag_q <= 1'b0;
		else
			trip_flag_q <= trip_flag_d;
	end

	// Analog controls and interrupt outputs, all registered.
	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			o_detector_power <= 1'b0;
			o_trip_level_select <= 4'h0;
			o_external_trip_sel <= 1'b0;
			o_irq <= 1'b0;
			o_wake <= 1'b0;
		end
		else
		begin
			o_detector_power <= enable; // [RQ1]
			o_trip_level_select <= lvl_field(ctrl_q); // [RQ5]
			o_external_trip_sel <= (lvl_field(ctrl_q) == `SVTD_LVL_EXT); // [RQ6]
			o_irq <= trip_flag_q && mask_q && gie_q; // [RQ11]
			// Wake does not need the global enable, as a sleeping core must resume.
			o_wake <= trip_flag_q && mask_q; // [RQ14]
		end
	end

	// Read channel: one outstanding read, answer one cycle after acceptance.
	assign o_s_axi_arready = !rvalid_q;
	assign o_s_axi_rvalid = rvalid_q;
	assign o_s_axi_rdata = rdata_q;
	assign o_s_axi_rresp = rresp_q;
	assign rd_go = i_s_axi_arvalid && !rvalid_q;

	// Read word assembly. The two stability bits are live status, never stored.
	always @*
	begin
		rdata_d = 32'h0000_0000;
		case (i_s_axi_araddr)
			`SVTD_OFF_CTRL:
				rdata_d = {24'h00_0000, ctrl_q[`SVTD_DIR_BIT], i_bandgap_stable, rvst_q,
					ctrl_q[`SVTD_EN_BIT], lvl_field(ctrl_q)}; // [RQ2] [RQ7]
			`SVTD_OFF_STAT:
				rdata_d = {31'h0000_0000, trip_flag_q}; // [RQ8]
			`SVTD_OFF_MASK:
				rdata_d = {31'h0000_0000, mask_q};
			`SVTD_OFF_GIE:
				rdata_d = {31'h0000_0000, gie_q};
			default:
				rdata_d = 32'h0000_0000;
		endcase
	end

	always @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `SVTD_RESP_OK;
		end
		else if (rd_go)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= bus_resp(i_s_axi_araddr);
			rdata_q <= rdata_d;
		end
		else if (rvalid_q && i_s_axi_rready)
			rvalid_q <= 1'b0;
	end
endmodule // svtd_detector
`default_nettype wire

//--- dv/svtd_detector_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module svtd_detector_monitor
(
	input wire i_ref_clk,
	input wire i_rst,
	input wire i_s_axi_wvalid,
	input wire i_cmp_below_async,
	input wire i_cmp_above_async,
	input wire o_detector_power,
	input wire [3:0] o_trip_level_select,
	input wire o_external_trip_sel,
	input wire o_irq,
	input wire o_wake
);
	// Cycles since power came on, saturating, to catch a trip flagged before settling.
	logic [5:0] on_q;
	always @(posedge i_ref_clk)
	begin
		if (i_rst || !o_detector_power)
			on_q <= 6'h00;
		else if (on_q != 6'h3F)
			on_q <= on_q + 6'h01;
	end
	wire any_w = i_cmp_below_async | i_cmp_above_async;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	a_ext_route: assert property (o_trip_level_select == 4'hF [*2] |-> o_external_trip_sel)
		else $error("external input not routed");
	a_ext_only: assert property (o_external_trip_sel |-> o_trip_level_select == 4'hF
		|| $past(o_trip_level_select) == 4'hF) else $error("external route on wrong code");
	a_irq_gate: assert property (o_irq |-> o_wake)
		else $error("irq without unmasked flag");
	a_irq_drop: assert property ($fell(o_wake) |-> !o_irq)
		else $error("irq stays after flag gone");
	a_settle_gate: assert property ($rose(o_wake) |-> on_q >= 6'h32)
		else $error("trip flagged before settling");
	a_sync_depth: assert property ($rose(o_wake) |-> $past(any_w, 3))
		else $error("trip without synchronised cause");
	a_flag_sticky: assert property ($fell(o_wake) |-> $past(i_s_axi_wvalid, 2)
		|| $past(i_s_axi_wvalid, 3)) else $error("flag dropped without a clear");
	a_reset_state: assert property ($fell(i_rst) |=> o_trip_level_select == 4'h4
		&& !o_detector_power) else $error("control not at reset state");
	c_irq: cover property ($rose(o_irq));
	c_ext: cover property ($rose(o_external_trip_sel));
	c_trip: cover property ($rose(o_wake));
endmodule // svtd_detector_monitor
bind svtd_detector svtd_detector_monitor u_mon (.i_ref_clk, .i_rst, .i_s_axi_wvalid,
	.i_cmp_below_async, .i_cmp_above_async, .o_detector_power, .o_trip_level_select,
	.o_external_trip_sel, .o_irq, .o_wake);
`default_nettype wire

//--- dv/svtd_detector_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module svtd_detector_tb_top;
	logic i_ref_clk = 1'h0;
	logic i_rst = 1'h1;
	logic [3:0] i_s_axi_awaddr = 4'h0, i_s_axi_araddr = 4'h0, i_s_axi_wstrb = 4'hF;
	logic [31:0] i_s_axi_wdata = 32'h0;
	logic i_s_axi_awvalid = 1'h0, i_s_axi_wvalid = 1'h0, i_s_axi_bready = 1'h0;
	logic i_s_axi_arvalid = 1'h0, i_s_axi_rready = 1'h0;
	logic i_cmp_below_async = 1'h0, i_cmp_above_async = 1'h0, i_bandgap_stable = 1'h0;
	wire o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
	wire [1:0] o_s_axi_bresp, o_s_axi_rresp;
	wire [31:0] o_s_axi_rdata;
	wire o_detector_power, o_external_trip_sel, o_irq, o_wake;
	wire [3:0] o_trip_level_select;
	int bad_count = 0, n_compared = 0, cyc = 0;
	logic [31:0] rv;
	logic [1:0] rs;
	svtd_detector u_dut (.i_ref_clk, .i_rst, .i_s_axi_awaddr, .i_s_axi_awvalid,
		.o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
		.o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
		.o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
		.i_cmp_below_async, .i_cmp_above_async, .i_bandgap_stable, .o_detector_power,
		.o_trip_level_select, .o_external_trip_sel, .o_irq, .o_wake);
	always #10 i_ref_clk = ~i_ref_clk;
	// A hung handshake would stall forever, so cap the run.
	always @(posedge i_ref_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			bad_count++;
			wrap_up();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// Each channel is released at the edge that takes it; bready is raised together with awvalid and wvalid.
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= d;
		i_s_axi_awvalid <= 1'h1;
		i_s_axi_wvalid <= 1'h1;
		i_s_axi_bready <= 1'h1;
		do
		begin
			@(posedge i_ref_clk);
			if (o_s_axi_awready)
				i_s_axi_awvalid <= 1'h0;
			if (o_s_axi_wready)
				i_s_axi_wvalid <= 1'h0;
		end while (o_s_axi_bvalid !== 1'h1);
		i_s_axi_bready <= 1'h0;
		chk("bresp", o_s_axi_bresp, (a[1:0] == 2'h0) ? 2'h0 : 2'h2);
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge i_ref_clk);
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'h1;
		i_s_axi_rready <= 1'h1;
		do
		begin
			@(posedge i_ref_clk);
			if (o_s_axi_arready)
				i_s_axi_arvalid <= 1'h0;
		end while (o_s_axi_rvalid !== 1'h1);
		rv = o_s_axi_rdata;
		rs = o_s_axi_rresp;
		i_s_axi_rready <= 1'h0;
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] e);
		rd(a);
		chk("rdata", rv, e);
		chk("rresp", rs, (a[1:0] == 2'h0) ? 2'h0 : 2'h2);
	endtask
	task automatic t_reset;
		rc(4'h0, 32'h04);
		rc(4'h4, 32'h00);
		rc(4'h8, 32'h00);
		rc(4'hC, 32'h00);
		rd(4'h2);
		chk("rresp", rs, 2'h2);
		chk("rdata", rv, 32'h00);
		wr(4'h6, 32'h01);
		i_s_axi_wstrb <= 4'h0;
		wr(4'h8, 32'h01);
		i_s_axi_wstrb <= 4'hF;
		rc(4'h8, 32'h00);
		i_bandgap_stable <= 1'h1;
		rc(4'h0, 32'h44);
	endtask
	// The trip input is raised right after enable, so only the settle gate holds the flag back.
	task automatic t_enable;
		wr(4'h0, 32'h43);
		wr(4'h0, 32'h13);
		wr(4'h4, 32'h01);
		i_cmp_below_async <= 1'h1;
		chk("power", o_detector_power, 1'h1);
		chk("level", o_trip_level_select, 4'h3);
		rc(4'h0, 32'h53);
		repeat (20) @(posedge i_ref_clk);
		rc(4'h4, 32'h00);
		repeat (40) @(posedge i_ref_clk);
		rc(4'h0, 32'h73);
		rc(4'h4, 32'h01);
	endtask
	// The trip input stays high at first, so a clear in a trip cycle must lose.
	task automatic t_irq;
		wr(4'h8, 32'h01);
		@(posedge i_ref_clk);
		chk("irq", o_irq, 1'h0);
		chk("wake", o_wake, 1'h1);
		wr(4'hC, 32'h01);
		@(posedge i_ref_clk);
		chk("irq", o_irq, 1'h1);
		wr(4'h4, 32'h01);
		rc(4'h4, 32'h01);
		i_cmp_below_async <= 1'h0;
		wr(4'h4, 32'h01);
		rc(4'h4, 32'h00);
		chk("irq", o_irq, 1'h0);
	endtask
	task automatic t_dir;
		wr(4'h0, 32'h03);
		rc(4'h0, 32'h43);
		chk("power", o_detector_power, 1'h0);
		wr(4'h0, 32'h8F);
		wr(4'h0, 32'h9F);
		i_cmp_below_async <= 1'h1;
		repeat (60) @(posedge i_ref_clk);
		chk("ext", o_external_trip_sel, 1'h1);
		rc(4'h4, 32'h00);
		i_cmp_above_async <= 1'h1;
		repeat (5) @(posedge i_ref_clk);
		rc(4'h4, 32'h01);
	endtask
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Reset for three cycles, then the scenarios in turn.
	initial
	begin
		repeat (3) @(posedge i_ref_clk);
		i_rst <= 1'h0;
		t_reset();
		t_enable();
		t_irq();
		t_dir();
		wrap_up();
	end
endmodule // svtd_detector_tb_top
`default_nettype wire
